// ---- src/rlsi_top.sv ----
// receive line-status flags, special-character flags and summary interrupt routing
// assumes receiver strobes, status levels and the register port share sys_clk;
// only the clear-to-send pin is asynchronous
// Operation
// RULE1 - line-status flags belong to the last word read; reading status keeps them
// RULE2 - bit 7 follows the clear-to-send input level, zero when low
// RULE3 - noise during a character tags it, bit 5 on read
// RULE4 - long low line stores an all-zero character tagged as break
// RULE5 - missing stop bits tag the character with framing fault in bit 3
// RULE6 - parity mismatch tags the character with parity fault in bit 2
// RULE7 - multidrop mode skips parity; bit 2 carries the received ninth bit
// RULE8 - character into full queue is dropped and overrun bit 1 set
// RULE9 - overrun clears on status read or when queue drops below full
// RULE10 - stale flag bit 0 sets after programmed wait; push or pop restarts
// RULE11 - zero stale period never raises the stale flag
// RULE12 - enabled line flags 5..0 feed summary bit 0
// RULE13 - special enables gate special flags 5..0 into summary bit 1
// RULE14 - address character in multidrop mode sets special bit 5
// RULE15 - detected break sets special bit 4
// RULE16 - with detection on, flow characters set special bits 3..0
// RULE17 - reading special flags clears all of them
// RULE18 - status enables 6 and 5 route sleep and clock-ready into summary bit 2
// RULE19 - status enables 3..0 route input-change flags into summary bit 2
// RULE20 - summary bit 0 sets on enabled line flag, clears on summary read
// RULE21 - line enable register holds one enable per flag, bits 5..0
// RULE22 - noise, break, framing and parity flags travel with each queue entry
`timescale 1ns/1ns

module rlsi_fifo
  import rlsi_pkg::*;
#(
  parameter int WIDTH = RLSI_ENTRY_W,
  parameter int DEPTH = RLSI_FIFO_DEPTH
)(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] cnt;
    logic room;
    logic avail;
  } rlsi_fifo_s;

  // room resets high so ready reads high during reset, straight from a flop
  localparam rlsi_fifo_s RST_Q = '{room: 1'b1, default: '0};
  rlsi_fifo_s q, d;
  logic push;
  logic pop;

  assign in_ready = q.room;
  assign out_valid = q.avail;
  assign out_data = q.mem[q.rd];
  assign push = in_valid & q.room;
  assign pop = out_ready & q.avail;

  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wr] = in_data;
      d.wr = q.wr + 1'b1;
    end
    if (pop)
      d.rd = q.rd + 1'b1;
    if (push & ~pop)
      d.cnt = q.cnt + 1'b1;
    else if (pop & ~push)
      d.cnt = q.cnt - 1'b1;
    d.room = (d.cnt != FULL_CNT);
    d.avail = (d.cnt != '0);
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= RST_Q;
    else
      q <= d;
  end
endmodule : rlsi_fifo

module rlsi_top
  import rlsi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cts_pin,
  input wire logic rx_valid,
  input wire logic [RLSI_DATA_W-1:0] rx_data,
  input wire logic rx_ninth,
  input wire logic rx_noise,
  input wire logic rx_frame_fault,
  input wire logic rx_break,
  output logic rx_ready,
  input wire logic parity_enable,
  input wire logic parity_odd,
  input wire logic multidrop_mode,
  input wire logic special_detect_enable,
  input wire logic [RLSI_DATA_W-1:0] first_on_char,
  input wire logic [RLSI_DATA_W-1:0] second_on_char,
  input wire logic [RLSI_DATA_W-1:0] first_off_char,
  input wire logic [RLSI_DATA_W-1:0] second_off_char,
  input wire logic [RLSI_TCNT_W-1:0] stale_period_setting,
  input wire logic char_tick,
  input wire logic sleep_state_flag,
  input wire logic clock_settled_flag,
  input wire logic [3:0] input_change_flags,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [RLSI_ADDR_W-1:0] reg_addr,
  input wire logic [RLSI_DATA_W-1:0] reg_wdata,
  output logic [RLSI_DATA_W-1:0] reg_rdata,
  output logic line_error_summary,
  output logic special_char_summary,
  output logic general_status_summary
);
  typedef struct packed {
    logic cts_s1;
    logic cts_s2;
    logic [RLSI_FLAG_W-1:0] flags;
    logic ovr;
    logic stale;
    logic [RLSI_TCNT_W-1:0] tcnt;
    logic [7:0] line_en;
    logic [7:0] sc_en;
    logic [7:0] sc;
    logic [7:0] sts_en;
    logic [2:0] summ;
    logic [RLSI_DATA_W-1:0] rdata;
  } rlsi_state_s;

  rlsi_state_s q, d;

  logic in_valid;
  logic in_ready;
  logic [RLSI_ENTRY_W-1:0] in_entry;
  logic out_valid;
  logic [RLSI_ENTRY_W-1:0] out_entry;
  logic pop;
  logic push;
  logic drop;
  logic exp_parity;
  logic par_flag;
  logic [7:0] line_val;
  logic [7:0] sc_set;
  logic [7:0] sts_val;
  logic rd_summ;
  logic rd_line;
  logic rd_sc;

  // a break and a character never share a cycle; the break takes the slot
  assign in_valid = rx_valid | rx_break;
  assign push = in_valid & in_ready;
  assign drop = in_valid & ~in_ready;
  assign rd_summ = reg_rd & (reg_addr == OFS_SUMM);
  assign rd_line = reg_rd & (reg_addr == OFS_LINE);
  assign rd_sc = reg_rd & (reg_addr == OFS_SC);
  assign pop = reg_rd & (reg_addr == OFS_HOLD) & out_valid;

  assign exp_parity = (^rx_data) ^ parity_odd;

  always_comb
  begin
    // RULE7 ninth bit
    if (multidrop_mode)
      par_flag = rx_ninth;
    // RULE6 parity compare
    else
      par_flag = parity_enable & (rx_ninth != exp_parity);
  end

  always_comb
  begin
    in_entry = '0;
    // RULE4 zero break char
    if (rx_break)
    begin
      in_entry[RLSI_ENTRY_W-1:RLSI_FLAG_W] = BREAK_CHAR;
      in_entry[ENT_BREAK] = 1'b1;
    end
    // RULE22 flags ride entry
    else
    begin
      in_entry[RLSI_ENTRY_W-1:RLSI_FLAG_W] = rx_data;
      // RULE3 noise tag
      in_entry[ENT_NOISE] = rx_noise;
      // RULE5 framing tag
      in_entry[ENT_FRAME] = rx_frame_fault;
      in_entry[ENT_PARITY] = par_flag;
    end
  end

  rlsi_fifo #(
    .WIDTH(RLSI_ENTRY_W),
    .DEPTH(RLSI_FIFO_DEPTH)
  ) u_receive_queue (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_entry),
    .out_valid(out_valid),
    .out_ready(pop),
    .out_data(out_entry)
  );

  always_comb
  begin
    line_val = '0;
    // RULE2 live cts level
    line_val[LINE_CTS] = q.cts_s2;
    line_val[LINE_NOISE] = q.flags[ENT_NOISE];
    line_val[LINE_BREAK] = q.flags[ENT_BREAK];
    line_val[LINE_FRAME] = q.flags[ENT_FRAME];
    line_val[LINE_PARITY] = q.flags[ENT_PARITY];
    line_val[LINE_OVR] = q.ovr;
    line_val[LINE_STALE] = q.stale;
  end

  always_comb
  begin
    sc_set = '0;
    // RULE14 address char
    sc_set[SC_ADDR] = rx_valid & multidrop_mode & rx_ninth;
    // RULE15 break seen
    sc_set[SC_PAUSE] = rx_break;
    // RULE16 flow chars
    sc_set[SC_OFF2] = rx_valid & special_detect_enable & (rx_data == second_off_char);
    sc_set[SC_OFF1] = rx_valid & special_detect_enable & (rx_data == first_off_char);
    sc_set[SC_ON2] = rx_valid & special_detect_enable & (rx_data == second_on_char);
    sc_set[SC_ON1] = rx_valid & special_detect_enable & (rx_data == first_on_char);
  end

  always_comb
  begin
    sts_val = '0;
    sts_val[STS_SLEEP] = sleep_state_flag;
    sts_val[STS_CLOCK] = clock_settled_flag;
    sts_val[STS_GPI_TOP:0] = input_change_flags;
  end

  always_comb
  begin
    d = q;
    d.cts_s1 = cts_pin;
    d.cts_s2 = q.cts_s1;
    // RULE1 flags of popped word
    if (pop)
      d.flags = out_entry[RLSI_FLAG_W-1:0];
    // RULE9 overrun clear
    if (rd_line | in_ready)
      d.ovr = 1'b0;
    // RULE8 overrun set wins
    if (drop)
      d.ovr = 1'b1;
    // RULE10 stale counter restart
    // RULE11 zero period holds clear
    if (push | pop | ~out_valid | (stale_period_setting == '0))
    begin
      d.tcnt = '0;
      d.stale = 1'b0;
    end
    else if (char_tick & ~q.stale)
    begin
      d.tcnt = q.tcnt + 1'b1;
      // RULE11 zero period disables
      if ((stale_period_setting != '0) & (d.tcnt >= stale_period_setting))
        d.stale = 1'b1;
    end
    // RULE17 read clears specials, new events win
    if (rd_sc)
      d.sc = '0;
    d.sc = d.sc | sc_set;
    // RULE21 line enables write
    if (reg_wr & (reg_addr == OFS_LINE_EN))
      d.line_en = reg_wdata & LINE_EN_MASK;
    if (reg_wr & (reg_addr == OFS_SC_EN))
      d.sc_en = reg_wdata & SC_EN_MASK;
    if (reg_wr & (reg_addr == OFS_STS_EN))
      d.sts_en = reg_wdata & STS_EN_MASK;
    // RULE20 summary clear on read
    if (rd_summ)
      d.summ = '0;
    // RULE12 enabled line flags
    if (|(line_val & q.line_en))
      d.summ[SUM_LINE] = 1'b1;
    // RULE13 enabled special flags
    if (|(q.sc & q.sc_en))
      d.summ[SUM_SPECIAL] = 1'b1;
    // RULE18 sleep and clock routing
    // RULE19 input change routing
    if (|(sts_val & q.sts_en))
      d.summ[SUM_STATUS] = 1'b1;
    d.rdata = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        OFS_HOLD: d.rdata = out_valid ? out_entry[RLSI_ENTRY_W-1:RLSI_FLAG_W] : '0;
        OFS_SUMM: d.rdata = RLSI_DATA_W'(q.summ);
        OFS_LINE_EN: d.rdata = q.line_en;
        // RULE1 read leaves flags
        OFS_LINE: d.rdata = line_val;
        OFS_SC_EN: d.rdata = q.sc_en;
        OFS_SC: d.rdata = q.sc;
        OFS_STS_EN: d.rdata = q.sts_en;
        default: d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= d;
  end

  assign rx_ready = in_ready;
  assign reg_rdata = q.rdata;
  assign line_error_summary = q.summ[SUM_LINE];
  assign special_char_summary = q.summ[SUM_SPECIAL];
  assign general_status_summary = q.summ[SUM_STATUS];

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  a_cts_read_back: assert property ( // RULE2
    rd_line |=> reg_rdata[LINE_CTS] == $past(q.cts_s2))
    else $error("status bit 7 does not show synced clear-to-send");

  a_flags_hold: assert property ( // RULE1
    !pop |=> $stable(q.flags))
    else $error("line flags changed without a word read");

  a_break_entry: assert property ( // RULE4
    rx_break |-> in_entry == {BREAK_CHAR, 4'h4})
    else $error("break entry not all-zero with break tag");

  a_parity_tag: assert property ( // RULE6
    (rx_valid && !rx_break && !multidrop_mode && parity_enable)
      |-> in_entry[ENT_PARITY] == (rx_ninth != exp_parity))
    else $error("parity tag wrong");

  a_overrun_set: assert property ( // RULE8
    (drop && !pop) |=> q.ovr && $stable(u_receive_queue.q.cnt))
    else $error("overrun not flagged or queue changed");

  a_overrun_clear: assert property ( // RULE9
    (q.ovr && rd_line && !drop) |=> !q.ovr)
    else $error("overrun survived status read");

  a_stale_zero: assert property ( // RULE11
    (stale_period_setting == '0) [*2] |-> !q.stale)
    else $error("stale flag with zero period");

  a_stale_restart: assert property ( // RULE10
    (push || pop) |=> !q.stale && q.tcnt == '0)
    else $error("stale counter not restarted");

  a_addr_char: assert property ( // RULE14
    (rx_valid && multidrop_mode && rx_ninth) |=> q.sc[SC_ADDR])
    else $error("address character not flagged");

  a_special_clear: assert property ( // RULE17
    (rd_sc && sc_set == '0) |=> q.sc == '0 && reg_rdata == $past(q.sc))
    else $error("special flags not cleared by read");

  a_line_summary: assert property ( // RULE12
    (|(line_val & q.line_en)) |=> line_error_summary)
    else $error("enabled line flag did not reach summary");

  a_status_mask: assert property ( // RULE19
    (q.sts_en == '0 && rd_summ) |=> !general_status_summary)
    else $error("masked status reached summary");

  c_overrun: cover property (drop ##1 rd_line);
  c_break_read: cover property (rx_break ##[1:20] pop);
  c_stale: cover property ($rose(q.stale));
endmodule : rlsi_top

// ---- pkg/rlsi_pkg.sv ----
// register map, field positions and sizes for the receive line-status block
// assumes one 10 MHz system clock and a byte-wide internal register port
package rlsi_pkg;
  localparam int RLSI_ADDR_W = 5;
  localparam int RLSI_DATA_W = 8;
  localparam int RLSI_FLAG_W = 4;
  localparam int RLSI_ENTRY_W = RLSI_DATA_W + RLSI_FLAG_W;
  localparam int RLSI_FIFO_DEPTH = 16;
  localparam int RLSI_TCNT_W = 8;

  localparam logic [RLSI_ADDR_W-1:0] OFS_HOLD = 5'h00;
  localparam logic [RLSI_ADDR_W-1:0] OFS_SUMM = 5'h02;
  localparam logic [RLSI_ADDR_W-1:0] OFS_LINE_EN = 5'h03;
  localparam logic [RLSI_ADDR_W-1:0] OFS_LINE = 5'h04;
  localparam logic [RLSI_ADDR_W-1:0] OFS_SC_EN = 5'h05;
  localparam logic [RLSI_ADDR_W-1:0] OFS_SC = 5'h06;
  localparam logic [RLSI_ADDR_W-1:0] OFS_STS_EN = 5'h07;

  // line status bit positions
  localparam int LINE_CTS = 7;
  localparam int LINE_NOISE = 5;
  localparam int LINE_BREAK = 4;
  localparam int LINE_FRAME = 3;
  localparam int LINE_PARITY = 2;
  localparam int LINE_OVR = 1;
  localparam int LINE_STALE = 0;

  // special character bit positions
  localparam int SC_ADDR = 5;
  localparam int SC_PAUSE = 4;
  localparam int SC_OFF2 = 3;
  localparam int SC_OFF1 = 2;
  localparam int SC_ON2 = 1;
  localparam int SC_ON1 = 0;

  // summary bit positions
  localparam int SUM_LINE = 0;
  localparam int SUM_SPECIAL = 1;
  localparam int SUM_STATUS = 2;

  // status source positions, matching the status enable register
  localparam int STS_SLEEP = 6;
  localparam int STS_CLOCK = 5;
  localparam int STS_GPI_TOP = 3;

  // flag field positions inside a queue entry, below the data byte
  localparam int ENT_NOISE = 3;
  localparam int ENT_BREAK = 2;
  localparam int ENT_FRAME = 1;
  localparam int ENT_PARITY = 0;

  localparam logic [7:0] LINE_EN_MASK = 8'h3f;
  localparam logic [7:0] SC_EN_MASK = 8'h3f;
  localparam logic [7:0] STS_EN_MASK = 8'h6f;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [RLSI_DATA_W-1:0] BREAK_CHAR = 8'h00;
endpackage : rlsi_pkg

// ---- tb/rlsi_host.sv ----
// host model: requester on the byte-wide register port of the line-status block
// assumes strobes are sampled on the sys_clk rising edge, read data one cycle later
`timescale 1ns/1ns

module rlsi_host
  import rlsi_pkg::*;
(
  input wire logic sys_clk,
  output logic reg_rd,
  output logic reg_wr,
  output logic [RLSI_ADDR_W-1:0] reg_addr,
  output logic [RLSI_DATA_W-1:0] reg_wdata,
  input wire logic [RLSI_DATA_W-1:0] reg_rdata
);
  initial
  begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
  end

  // read data stands for one cycle only, so it is sampled mid-cycle
  task automatic rd(input logic [RLSI_ADDR_W-1:0] a, output logic [RLSI_DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask : rd

  task automatic wr(input logic [RLSI_ADDR_W-1:0] a, input logic [RLSI_DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
endmodule : rlsi_host

// ---- tb/tb.sv ----
// self-checking bench for the receive line-status block
// assumes the host model rlsi_host and a 10 MHz sys_clk
`timescale 1ns/1ns
`define CHK(g, e) cmp(8'(g), 8'(e))

module tb;
  import rlsi_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cts_pin = 1'b0;
  logic rx_valid = 1'b0, rx_ninth = 1'b0, rx_noise = 1'b0, rx_frame_fault = 1'b0;
  logic rx_break = 1'b0, parity_enable = 1'b0, parity_odd = 1'b0, multidrop_mode = 1'b0;
  logic special_detect_enable = 1'b0, char_tick = 1'b0;
  logic sleep_state_flag = 1'b0, clock_settled_flag = 1'b0;
  logic [RLSI_DATA_W-1:0] rx_data = 8'h00;
  logic [RLSI_TCNT_W-1:0] stale_period_setting = 8'h00;
  logic [3:0] input_change_flags = 4'h0;
  logic [RLSI_DATA_W-1:0] fc [4] = '{8'h11, 8'h12, 8'h13, 8'h14};
  logic [RLSI_ADDR_W-1:0] ens [3] = '{OFS_LINE_EN, OFS_SC_EN, OFS_STS_EN};
  logic [7:0] msk [3] = '{8'h3f, 8'h3f, 8'h6f};
  logic rx_ready, line_error_summary, special_char_summary, general_status_summary;
  logic reg_rd, reg_wr;
  logic [RLSI_ADDR_W-1:0] reg_addr;
  logic [RLSI_DATA_W-1:0] reg_wdata, reg_rdata;
  int bad_count = 0;
  int check_count = 0;

  rlsi_top rlsi_top_i (.sys_clk, .reset_n, .cts_pin, .rx_valid, .rx_data, .rx_ninth,
    .rx_noise, .rx_frame_fault, .rx_break, .rx_ready, .parity_enable, .parity_odd,
    .multidrop_mode, .special_detect_enable, .first_on_char(fc[0]),
    .second_on_char(fc[1]), .first_off_char(fc[2]), .second_off_char(fc[3]),
    .stale_period_setting, .char_tick, .sleep_state_flag, .clock_settled_flag,
    .input_change_flags, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
    .line_error_summary, .special_char_summary, .general_status_summary);

  rlsi_host rlsi_host_i (.sys_clk, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata);

  initial
  begin
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp

  task automatic results();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic rchk(input logic [RLSI_ADDR_W-1:0] a, input logic [7:0] e);
    logic [7:0] d;
    rlsi_host_i.rd(a, d);
    `CHK(d, e);
  endtask : rchk

  // f holds break, noise, framing and ninth bit
  task automatic push(input logic [7:0] d, input logic [3:0] f);
    @(posedge sys_clk);
    rx_valid <= ~f[3];
    rx_break <= f[3];
    rx_data <= d;
    rx_noise <= f[2];
    rx_frame_fault <= f[1];
    rx_ninth <= f[0];
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_break <= 1'b0;
  endtask : push

  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      char_tick <= 1'b1;
      @(posedge sys_clk);
      char_tick <= 1'b0;
    end
  endtask : tick

  initial
  begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    rchk(OFS_LINE, 8'h00);
    `CHK(rx_ready, 1'b1);
    rchk(5'h1f, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      rchk(ens[i], 8'h00);
      rlsi_host_i.wr(ens[i], 8'hff);
      rchk(ens[i], msk[i]);
      rlsi_host_i.wr(ens[i], 8'h00);
    end
    push(8'h41, 4'b0100);
    rchk(OFS_HOLD, 8'h41);
    rchk(OFS_LINE, 8'h20);
    rchk(OFS_LINE, 8'h20);
    `CHK(line_error_summary, 1'b0);
    rlsi_host_i.wr(OFS_LINE_EN, 8'h20);
    repeat (2) @(negedge sys_clk);
    `CHK(line_error_summary, 1'b1);
    rchk(OFS_SUMM, 8'h01);
    rlsi_host_i.wr(OFS_LINE_EN, 8'h00);
    parity_enable <= 1'b1;
    push(8'h03, 4'b0011);
    rchk(OFS_HOLD, 8'h03);
    rchk(OFS_LINE, 8'h0c);
    // level inputs change on a rising edge, after the read's mid-cycle sample
    @(posedge sys_clk);
    parity_odd <= 1'b1;
    push(8'h03, 4'b0001);
    rchk(OFS_HOLD, 8'h03);
    rchk(OFS_LINE, 8'h00);
    // parity would flag 0x00 with ninth low under odd parity
    @(posedge sys_clk);
    multidrop_mode <= 1'b1;
    push(8'h00, 4'b0000);
    rchk(OFS_HOLD, 8'h00);
    rchk(OFS_LINE, 8'h00);
    push(8'h05, 4'b0001);
    rchk(OFS_HOLD, 8'h05);
    rchk(OFS_LINE, 8'h04);
    rchk(OFS_SC, 8'h20);
    rchk(OFS_SC, 8'h00);
    `CHK(special_char_summary, 1'b0);
    @(posedge sys_clk);
    multidrop_mode <= 1'b0;
    parity_enable <= 1'b0;
    rlsi_host_i.wr(OFS_SC_EN, 8'h10);
    push(8'h5a, 4'b1000);
    rchk(OFS_HOLD, BREAK_CHAR);
    rchk(OFS_LINE, 8'h10);
    `CHK(special_char_summary, 1'b1);
    rchk(OFS_SC, 8'h10);
    push(fc[0], 4'b0000);
    rchk(OFS_HOLD, fc[0]);
    rchk(OFS_SC, 8'h00);
    @(posedge sys_clk);
    special_detect_enable <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      push(fc[i], 4'b0000);
      rchk(OFS_HOLD, fc[i]);
      rchk(OFS_SC, 8'h01 << i);
    end
    for (int i = 0; i < 16; i++)
      push(8'h80 + 8'(i), 4'b0000);
    @(negedge sys_clk);
    `CHK(rx_ready, 1'b0);
    push(8'hff, 4'b0000);
    rchk(OFS_LINE, 8'h02);
    rchk(OFS_LINE, 8'h00);
    for (int i = 0; i < 16; i++)
      rchk(OFS_HOLD, 8'h80 + 8'(i));
    rchk(OFS_HOLD, 8'h00);
    `CHK(rx_ready, 1'b1);
    @(posedge sys_clk);
    stale_period_setting <= 8'd2;
    push(8'h33, 4'b0000);
    tick(3);
    rchk(OFS_LINE, 8'h01);
    rchk(OFS_HOLD, 8'h33);
    rchk(OFS_LINE, 8'h00);
    @(posedge sys_clk);
    stale_period_setting <= 8'd0;
    push(8'h34, 4'b0000);
    tick(5);
    rchk(OFS_LINE, 8'h00);
    rchk(OFS_HOLD, 8'h34);
    @(posedge sys_clk);
    sleep_state_flag <= 1'b1;
    input_change_flags <= 4'h4;
    rlsi_host_i.wr(OFS_STS_EN, 8'h02);
    repeat (3) @(negedge sys_clk);
    `CHK(general_status_summary, 1'b0);
    rlsi_host_i.wr(OFS_STS_EN, 8'h04);
    repeat (2) @(negedge sys_clk);
    `CHK(general_status_summary, 1'b1);
    @(posedge sys_clk);
    sleep_state_flag <= 1'b0;
    input_change_flags <= 4'h0;
    rlsi_host_i.wr(OFS_STS_EN, 8'h00);
    rchk(OFS_SUMM, 8'h07);
    rchk(OFS_SUMM, 8'h00);
    @(posedge sys_clk);
    sleep_state_flag <= 1'b1;
    rlsi_host_i.wr(OFS_STS_EN, 8'h40);
    repeat (2) @(negedge sys_clk);
    `CHK(general_status_summary, 1'b1);
    @(posedge sys_clk);
    cts_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rchk(OFS_LINE, 8'h80);
    results();
  end

  // the whole sequence needs well under 1500 cycles
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    results();
  end
endmodule : tb
